// ===== wu_pkg.sv
// Shared constants, register map and command decode for the sector-marking command block
package wu_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 50;
  localparam int RECOVERY_TIME_US = 100;
  localparam int RECOVERY_CYCLES  = RECOVERY_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] FEATURE_OFS     = 6'h00;
  localparam logic [5:0] COUNT_CUR_OFS   = 6'h04;
  localparam logic [5:0] COUNT_PREV_OFS  = 6'h08;
  localparam logic [5:0] SECNUM_CUR_OFS  = 6'h0c;
  localparam logic [5:0] SECNUM_PREV_OFS = 6'h10;
  localparam logic [5:0] CYLLO_CUR_OFS   = 6'h14;
  localparam logic [5:0] CYLLO_PREV_OFS  = 6'h18;
  localparam logic [5:0] CYLHI_CUR_OFS   = 6'h1c;
  localparam logic [5:0] CYLHI_PREV_OFS  = 6'h20;
  localparam logic [5:0] DEVHEAD_OFS     = 6'h24;
  localparam logic [5:0] COMMAND_OFS     = 6'h28;
  localparam logic [5:0] STATUS_OFS      = 6'h2c;
  localparam logic [5:0] ERROR_OFS       = 6'h30;
  localparam logic [5:0] CONTROL_OFS     = 6'h34;
  localparam logic [5:0] IRQ_STATUS_OFS  = 6'h38;
  localparam logic [5:0] IRQ_MASK_OFS    = 6'h3c;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int ERR_BAD_SECTOR_POS = 6;
  localparam int ERR_NOT_FOUND_POS  = 4;
  localparam int ERR_ABORTED_POS    = 2;
  localparam int ST_BUSY_POS        = 7;
  localparam int ST_READY_POS       = 6;
  localparam int ST_FAULT_POS       = 5;
  localparam int ST_SEEK_POS        = 4;
  localparam int ST_XFER_POS        = 3;
  localparam int ST_CORR_POS        = 2;
  localparam int ST_ERR_POS         = 0;
  localparam int CTRL_UPPER_POS     = 7;
  localparam int DEVHEAD_LBA_POS    = 6;
  localparam int IRQ_DONE_POS       = 0;
  localparam int IRQ_FAIL_POS       = 1;

  localparam logic [7:0] CMD_MARK_UNC  = 8'h45;
  localparam logic [7:0] FEAT_PSEUDO   = 8'h55;
  localparam logic [7:0] FEAT_FLAGGED  = 8'haa;
  localparam logic [7:0] STATUS_RESET  = 8'h50;
  localparam logic [7:0] ERROR_RESET   = 8'h00;
  localparam logic [1:0] IRQ_RESET     = 2'h0;

  // Sectors per physical block, as a power of two
  localparam int BLOCK_SHIFT = 3;
  localparam int MARK_SLOTS  = 16;

  // Read-class opcodes that report marked sectors
  function automatic logic isReadCmd(input logic [7:0] op);
    case (op)
      8'hc8, 8'h25, 8'hc4, 8'h29, 8'h20, 8'h24, 8'h40, 8'h42, 8'h2b, 8'h2a: isReadCmd = 1'b1;
      default: isReadCmd = 1'b0;
    endcase
  endfunction : isReadCmd

  // Write-class opcodes that clear marks
  function automatic logic isWriteCmd(input logic [7:0] op);
    case (op)
      8'hca, 8'h35, 8'hc5, 8'h39, 8'h30, 8'h34, 8'h3b, 8'h3a: isWriteCmd = 1'b1;
      default: isWriteCmd = 1'b0;
    endcase
  endfunction : isWriteCmd

endpackage : wu_pkg

// ===== mark_store.sv
// Persistent table of pseudo and flagged sector marks
`timescale 1ns/1ps
`default_nettype none
module mark_store (
  input  wire logic        clk,
  input  wire logic        powerOnRst,
  input  wire logic [47:0] lookupLba,
  output logic             hit,
  output logic             hitPseudo,
  output logic             full,
  input  wire logic        insertEn,
  input  wire logic        insertPseudo,
  input  wire logic        clearEn
);
  import wu_pkg::*;

  logic [47:0] key   [MARK_SLOTS];
  logic        pseudo[MARK_SLOTS];
  logic [MARK_SLOTS-1:0] valid;
  logic [MARK_SLOTS-1:0] match;
  logic [MARK_SLOTS-1:0] same;
  logic [47:0] insertKey;
  int          freeIdx;
  int          sameIdx;

  // Pseudo marks cover the whole physical block holding the sector
  function automatic logic covers(input logic [47:0] k, input logic p, input logic [47:0] a);
    covers = p ? (k[47:BLOCK_SHIFT] == a[47:BLOCK_SHIFT]) : (k == a);
  endfunction : covers

  assign insertKey = insertPseudo ? {lookupLba[47:BLOCK_SHIFT], {BLOCK_SHIFT{1'b0}}} : lookupLba;

  // Lookup, duplicate detection and free-slot search
  always_comb begin
    freeIdx = -1;
    sameIdx = -1;
    for (int i = 0; i < MARK_SLOTS; i++) begin
      match[i] = valid[i] && covers(key[i], pseudo[i], lookupLba);
      same[i]  = valid[i] && key[i] == insertKey && pseudo[i] == insertPseudo;
      if (same[i]) sameIdx = i;
      if (!valid[i] && freeIdx < 0) freeIdx = i;
    end
  end

  assign hit  = |match;
  assign full = (freeIdx < 0) && (sameIdx < 0);

  // Any pseudo match makes the sector pseudo; recovery is then run in full
  always_comb begin
    hitPseudo = 1'b0;
    for (int i = 0; i < MARK_SLOTS; i++) begin
      if (match[i] && pseudo[i]) hitPseudo = 1'b1;
    end
  end

  // Valid bits clear at power-on reset and on a clean write; ordinary reset keeps the marks
  always_ff @(posedge clk or posedge powerOnRst) begin
    if (powerOnRst) begin
      valid <= '0;
    end else if (clearEn) begin
      valid <= valid & ~match;
    end else if (insertEn && sameIdx < 0 && freeIdx >= 0) begin
      valid[freeIdx] <= 1'b1;
    end
  end

  // Key storage needs no reset
  always_ff @(posedge clk) begin
    if (insertEn && sameIdx < 0 && freeIdx >= 0) begin
      key[freeIdx]    <= insertKey;
      pseudo[freeIdx] <= insertPseudo;
    end
  end

endmodule : mark_store
`default_nettype wire

// ===== irq_ctrl.sv
// Sticky event status, mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] events,
  input  wire logic       statusWrite,
  input  wire logic       maskWrite,
  input  wire logic [1:0] writeData,
  output logic      [1:0] status,
  output logic      [1:0] mask,
  output logic            irq
);
  import wu_pkg::*;

  // A new event in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status <= IRQ_RESET;
      mask   <= IRQ_RESET;
      irq    <= 1'b0;
    end else begin
      status <= (status & ~(statusWrite ? writeData : 2'h0)) | events;
      if (maskWrite) mask <= writeData;
      irq    <= |(((status & ~(statusWrite ? writeData : 2'h0)) | events) & (maskWrite ? writeData : mask));
    end
  end

endmodule : irq_ctrl
`default_nettype wire

// ===== write_uncorrectable_marker.sv
// Task-file command handler that marks, reports and clears uncorrectable sectors
`timescale 1ns/1ps
`default_nettype none
module write_uncorrectable_marker #(
  parameter int RECOVERY_COUNT = wu_pkg::RECOVERY_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        powerOnRst,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        mediaDefect,
  output logic             irq
);
  import wu_pkg::*;

  typedef enum logic [2:0] {
    IDLE      = 3'b000,
    MARK      = 3'b001,
    READ_CHK  = 3'b010,
    RECOVER   = 3'b011,
    WRITE_CLR = 3'b100,
    WRITE_VFY = 3'b101
  } state_type;

  // ----------------------------------------------------------------
  // Task-file storage
  // ----------------------------------------------------------------
  logic [7:0]  feature;
  logic [7:0]  countCur;
  logic [7:0]  countPrev;
  logic [47:0] lbaIn;
  logic [7:0]  devHead;
  logic [7:0]  command;
  logic [7:0]  errorFlags;
  logic [7:0]  statusFlags;
  logic        upperByteSelect;
  logic [47:0] failLba;

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  state_type   state;
  state_type   next_state;
  logic [47:0] curLba;
  logic [16:0] remaining;
  logic [31:0] recoverCount;
  logic        pseudoMode;
  logic        ack;
  logic [1:0]  events;

  logic        storeHit;
  logic        storeHitPseudo;
  logic        storeFull;
  logic        insertEn;
  logic        clearEn;
  logic [1:0]  irqStatus;
  logic [1:0]  irqMask;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire         writeTake   = write && ack;
  wire         busy        = state != IDLE;
  wire         cmdWrite    = writeTake && address == COMMAND_OFS && !busy;
  wire [7:0]   wrByte      = writedata[7:0];
  wire         isMark      = wrByte == CMD_MARK_UNC;
  wire         featPseudo  = feature == FEAT_PSEUDO;
  wire         featFlagged = feature == FEAT_FLAGGED;
  wire         featBad     = !featPseudo && !featFlagged;
  wire [15:0]  rawCount    = {countPrev, countCur};
  wire [16:0]  fullCount   = (rawCount == 16'h0000) ? 17'h10000 : {1'b0, rawCount};
  wire         lastSector  = remaining == 17'h00001;
  wire         recoverDone = recoverCount >= RECOVERY_COUNT - 1;
  wire         startMark   = cmdWrite && isMark && !featBad;
  wire         startRead   = cmdWrite && isReadCmd(wrByte);
  wire         startWrite  = cmdWrite && isWriteCmd(wrByte);

  // Returned address half chosen by upper-byte select
  wire [23:0]  retBytes = upperByteSelect ? failLba[47:24] : failLba[23:0];

  // Read data mux; unmapped reads return zero
  logic [7:0] rdByte;
  always_comb begin
    case (address)
      FEATURE_OFS:     rdByte = feature;
      COUNT_CUR_OFS:   rdByte = countCur;
      COUNT_PREV_OFS:  rdByte = countPrev;
      SECNUM_CUR_OFS:  rdByte = retBytes[7:0];
      CYLLO_CUR_OFS:   rdByte = retBytes[15:8];
      CYLHI_CUR_OFS:   rdByte = retBytes[23:16];
      SECNUM_PREV_OFS: rdByte = lbaIn[31:24];
      CYLLO_PREV_OFS:  rdByte = lbaIn[39:32];
      CYLHI_PREV_OFS:  rdByte = lbaIn[47:40];
      DEVHEAD_OFS:     rdByte = devHead;
      COMMAND_OFS:     rdByte = command;
      STATUS_OFS:      rdByte = statusFlags;
      ERROR_OFS:       rdByte = errorFlags;
      CONTROL_OFS:     rdByte = {upperByteSelect, 7'h00};
      IRQ_STATUS_OFS:  rdByte = {6'h00, irqStatus};
      IRQ_MASK_OFS:    rdByte = {6'h00, irqMask};
      default:         rdByte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Avalon slave handshake: one wait cycle on every access
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack         <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      ack         <= (read || write) && !ack;
      waitrequest <= !((read || write) && !ack);
      if (read && !ack) readdata <= {24'h000000, rdByte};
    end
  end

  // ----------------------------------------------------------------
  // Host-written task-file registers
  // ----------------------------------------------------------------
  // Written while busy they are ignored, so the running command stays consistent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      feature         <= 8'h00;
      countCur        <= 8'h00;
      countPrev       <= 8'h00;
      lbaIn           <= 48'h0000_0000_0000;
      devHead         <= 8'h00;
      command         <= 8'h00;
      upperByteSelect <= 1'b0;
    end else if (writeTake && !busy) begin
      case (address)
        FEATURE_OFS:     feature         <= wrByte;
        COUNT_CUR_OFS:   countCur        <= wrByte;
        COUNT_PREV_OFS:  countPrev       <= wrByte;
        SECNUM_CUR_OFS:  lbaIn[7:0]      <= wrByte;
        CYLLO_CUR_OFS:   lbaIn[15:8]     <= wrByte;
        CYLHI_CUR_OFS:   lbaIn[23:16]    <= wrByte;
        SECNUM_PREV_OFS: lbaIn[31:24]    <= wrByte;
        CYLLO_PREV_OFS:  lbaIn[39:32]    <= wrByte;
        CYLHI_PREV_OFS:  lbaIn[47:40]    <= wrByte;
        DEVHEAD_OFS:     devHead         <= wrByte;
        COMMAND_OFS:     command         <= wrByte;
        CONTROL_OFS:     upperByteSelect <= wrByte[CTRL_UPPER_POS];
        default:         feature         <= feature;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sector engine
  // ----------------------------------------------------------------
  // Store operations are single-cycle and driven from the current state
  assign insertEn = state == MARK && !storeFull;
  assign clearEn  = state == WRITE_CLR && !mediaDefect;

  always_comb begin
    next_state = state;
    case (state)
      IDLE: begin
        if (startMark) next_state = MARK;
        else if (startRead) next_state = READ_CHK;
        else if (startWrite) next_state = WRITE_CLR;
      end
      MARK: begin
        if (storeFull || lastSector) next_state = IDLE;
      end
      READ_CHK: begin
        if (storeHitPseudo) next_state = RECOVER;
        else if (storeHit || mediaDefect || lastSector) next_state = IDLE;
      end
      RECOVER: begin
        if (recoverDone) next_state = IDLE;
      end
      WRITE_CLR: begin
        if (mediaDefect) next_state = IDLE;
        else next_state = WRITE_VFY;
      end
      WRITE_VFY: begin
        if (storeHit || mediaDefect || lastSector) next_state = IDLE;
        else next_state = WRITE_CLR;
      end
      default: next_state = IDLE;
    endcase
  end

  // Sector walk: the address and count step when a sector passes clean
  wire stepRead  = state == READ_CHK && !storeHit && !mediaDefect && !lastSector;
  wire stepMark  = state == MARK && !storeFull && !lastSector;
  wire stepWrite = state == WRITE_VFY && !storeHit && !mediaDefect && !lastSector;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state        <= IDLE;
      curLba       <= 48'h0000_0000_0000;
      remaining    <= 17'h00000;
      recoverCount <= 32'h0000_0000;
      pseudoMode   <= 1'b0;
    end else begin
      state <= next_state;
      if (state == IDLE) begin
        curLba     <= lbaIn;
        remaining  <= fullCount;
        pseudoMode <= featPseudo;
      end else if (stepRead || stepMark || stepWrite) begin
        curLba    <= curLba + 48'h0000_0000_0001;
        remaining <= remaining - 17'h00001;
      end
      recoverCount <= (state == RECOVER) ? recoverCount + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Completion status and error reporting
  // ----------------------------------------------------------------
  wire finishing  = busy && next_state == IDLE;
  wire failMark   = state == MARK && storeFull;
  wire failRead   = (state == READ_CHK && !storeHitPseudo && (storeHit || mediaDefect))
                    || (state == RECOVER && recoverDone);
  wire failWrite  = (state == WRITE_CLR && mediaDefect)
                    || (state == WRITE_VFY && (storeHit || mediaDefect));
  wire failAny    = failMark || failRead || failWrite;
  wire abortFeat  = cmdWrite && isMark && featBad;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusFlags <= STATUS_RESET;
      errorFlags  <= ERROR_RESET;
      failLba     <= 48'h0000_0000_0000;
      events      <= 2'h0;
    end else begin
      events <= 2'h0;
      if (startMark || startRead || startWrite) begin
        statusFlags <= 8'h00 | (8'h01 << ST_BUSY_POS);
        errorFlags  <= ERROR_RESET;
      end else if (abortFeat) begin
        errorFlags  <= 8'h01 << ERR_ABORTED_POS;
        statusFlags <= (8'h01 << ST_READY_POS) | (8'h01 << ST_SEEK_POS) | (8'h01 << ST_ERR_POS);
        events      <= 2'h3;
      end else if (finishing) begin
        // Fault, corrected and busy always clear; ready and seek always set, error is the result
        statusFlags <= (8'h01 << ST_READY_POS) | (8'h01 << ST_SEEK_POS)
                       | (failAny ? (8'h01 << ST_ERR_POS) : 8'h00);
        errorFlags  <= failMark ? (8'h01 << ERR_ABORTED_POS)
                     : failRead ? (8'h01 << ERR_BAD_SECTOR_POS)
                     : failWrite ? (8'h01 << ERR_NOT_FOUND_POS)
                     : ERROR_RESET;
        if (failAny) failLba <= curLba;
        events <= {failAny, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Mark table lives outside ordinary reset so marks survive it
  mark_store u_store (
    .clk          (clk),
    .powerOnRst   (powerOnRst),
    .lookupLba    (curLba),
    .hit          (storeHit),
    .hitPseudo    (storeHitPseudo),
    .full         (storeFull),
    .insertEn     (insertEn),
    .insertPseudo (pseudoMode),
    .clearEn      (clearEn)
  );

  irq_ctrl u_irq (
    .clk         (clk),
    .rst         (rst),
    .events      (events),
    .statusWrite (writeTake && address == IRQ_STATUS_OFS),
    .maskWrite   (writeTake && address == IRQ_MASK_OFS),
    .writeData   (writedata[1:0]),
    .status      (irqStatus),
    .mask        (irqMask),
    .irq         (irq)
  );

endmodule : write_uncorrectable_marker
`default_nettype wire

// ===== wu_host.sv
// Host controller model that drives the task-file registers over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module wu_host (
  output logic      [5:0]  address,
  output logic             read,
  output logic             write,
  output logic      [31:0] writedata,
  input  wire logic        clk,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  import wu_pkg::*;
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  // Idle bus from time zero
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end
  // Held until waitrequest is seen low; a released bus shows inverted values, never stale ones
  task automatic access(input logic rd, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~d;
  endtask : access
  // Full command setup: feature, count, six address bytes, address mode, opcode last
  task automatic issue(input logic [7:0] f, input logic [15:0] c, input logic [47:0] lba, input logic [7:0] op);
    logic [5:0]  ofs [6] = '{SECNUM_CUR_OFS, CYLLO_CUR_OFS, CYLHI_CUR_OFS, SECNUM_PREV_OFS, CYLLO_PREV_OFS,
                             CYLHI_PREV_OFS};
    logic [31:0] q;
    access(1'b0, FEATURE_OFS, {24'h0, f}, q);
    access(1'b0, COUNT_CUR_OFS, {24'h0, c[7:0]}, q);
    access(1'b0, COUNT_PREV_OFS, {24'h0, c[15:8]}, q);
    for (int i = 0; i < 6; i++) access(1'b0, ofs[i], {24'h0, lba[8*i +: 8]}, q);
    access(1'b0, DEVHEAD_OFS, 32'h40, q);
    access(1'b0, COMMAND_OFS, {24'h0, op}, q);
  endtask : issue
  // Poll status until busy drops; the bench watchdog bounds a hang
  task automatic waitDone(output logic [7:0] st);
    logic [31:0] q;
    do access(1'b1, STATUS_OFS, 32'h0, q); while (q[7] === 1'b1);
    st = q[7:0];
  endtask : waitDone
endmodule : wu_host
`default_nettype wire

// ===== write_uncorrectable_marker_props.sv
// Handshake, status and interrupt assertions for the sector-marking command block
`timescale 1ns/1ps
`default_nettype none
module write_uncorrectable_marker_props
  import wu_pkg::*;
#(
  parameter int RECOVERY_COUNT = RECOVERY_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        powerOnRst,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        mediaDefect,
  input wire logic        irq
);
  logic [1:0] maskShadow;
  // Completed accesses by register
  wire logic statusRead = read && !waitrequest && address == STATUS_OFS;
  wire logic errorRead  = read && !waitrequest && address == ERROR_OFS;
  wire logic maskRead   = read && !waitrequest && address == IRQ_MASK_OFS;
  wire logic maskWrite  = write && !waitrequest && address == IRQ_MASK_OFS;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Mask copy taken from the bus, so irq can be judged without looking inside
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskShadow <= 2'h0;
    end else if (maskWrite) begin
      maskShadow <= writedata[1:0];
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  chk_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_wait_idle: assert property (!(read || write) |=> waitrequest)
    else $error("waitrequest low with no request");
  chk_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without a request");
  chk_data_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_status_clear: assert property (statusRead |-> readdata[5] == 1'b0 && readdata[2] == 1'b0)
    else $error("fault or corrected status bit set");
  chk_status_ready: assert property (statusRead && !readdata[7] |-> readdata[6])
    else $error("ready clear while not busy");
  chk_error_bits: assert property (errorRead |-> (readdata[7:0] & 8'hab) == 8'h00)
    else $error("reserved error bit set");
  chk_mask_read: assert property (maskRead |-> readdata[1:0] == maskShadow)
    else $error("mask readback differs from last write");
  chk_irq_masked: assert property (maskShadow == 2'h0 && $past(maskShadow) == 2'h0 |-> !irq)
    else $error("irq high with all events masked");
endmodule : write_uncorrectable_marker_props
bind write_uncorrectable_marker write_uncorrectable_marker_props #(.RECOVERY_COUNT(RECOVERY_COUNT)) i_props (
  .clk(clk), .rst(rst), .powerOnRst(powerOnRst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .mediaDefect(mediaDefect), .irq(irq));
`default_nettype wire

// ===== write_uncorrectable_marker_tb_top.sv
// Self-checking bench for the sector-marking command block
`timescale 1ns/1ps
`default_nettype none
module write_uncorrectable_marker_tb_top;
  import wu_pkg::*;
  localparam int          REC = 40;  // Short recovery keeps the run brief but above poll granularity
  localparam logic [47:0] LBA = 48'h665544332211;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        powerOnRst = 1'b1;
  logic        mediaDefect = 1'b0;
  logic [5:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic [31:0] q;
  int          cyc;
  int          miscompares = 0;
  int          total_checks = 0;
  logic [7:0]  rdOps [10] = '{8'hc8, 8'h25, 8'hc4, 8'h29, 8'h20, 8'h24, 8'h40, 8'h42, 8'h2b, 8'h2a};
  logic [5:0]  lbaOfs [3] = '{SECNUM_CUR_OFS, CYLLO_CUR_OFS, CYLHI_CUR_OFS};
  always #10 clk = ~clk;
  write_uncorrectable_marker #(.RECOVERY_COUNT(REC)) i_write_uncorrectable_marker (
    .clk(clk), .rst(rst), .powerOnRst(powerOnRst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .mediaDefect(mediaDefect), .irq(irq));
  wu_host i_wu_host (.clk(clk), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results
  task automatic rd(input logic [5:0] a);
    i_wu_host.access(1'b1, a, 32'h0, q);
  endtask : rd
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_wu_host.access(1'b0, a, d, q);
  endtask : wr
  // One command to completion; elapsed cycles counted from the opcode write
  task automatic runCmd(input logic [7:0] f, input logic [15:0] c, input logic [47:0] a, input logic [7:0] op,
                        input logic [7:0] st, input logic [7:0] er, output int n);
    logic [7:0] s;
    longint     t;
    i_wu_host.issue(f, c, a, op);
    t = $time;
    i_wu_host.waitDone(s);
    n = int'(($time - t) / 20);
    check("status", {24'h0, s}, {24'h0, st});
    rd(ERROR_OFS);
    check("error", q, {24'h0, er});
  endtask : runCmd
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    rd(STATUS_OFS);
    check("status at reset", q, 32'h50);
    rd(IRQ_MASK_OFS);
    check("mask at reset", q, 32'h0);
    rd(6'h02);
    check("unmapped read", q, 32'h0);
  endtask : testReset
  task automatic testFlagged();
    runCmd(8'haa, 16'h1, LBA, 8'h45, 8'h50, 8'h00, cyc);
    foreach (rdOps[i]) runCmd(8'h00, 16'h1, LBA, rdOps[i], 8'h51, 8'h40, cyc);
    for (int i = 0; i < 6; i++) begin
      if (i % 3 == 0) wr(CONTROL_OFS, (i == 3) ? 32'h80 : 32'h0);
      rd(lbaOfs[i % 3]);
      check("failing address byte", q, {24'h0, LBA[8*i +: 8]});
    end
    wr(CONTROL_OFS, 32'h0);
    runCmd(8'h00, 16'h1, LBA + 48'h1, 8'h20, 8'h50, 8'h00, cyc);
    runCmd(8'h00, 16'h1, LBA, 8'h30, 8'h50, 8'h00, cyc);
    runCmd(8'h00, 16'h1, LBA, 8'h20, 8'h50, 8'h00, cyc);
  endtask : testFlagged
  task automatic testPseudo();
    runCmd(8'h55, 16'h1, 48'h13, 8'h45, 8'h50, 8'h00, cyc);
    runCmd(8'h00, 16'h1, 48'h17, 8'h25, 8'h51, 8'h40, cyc);
    check("recovery wait", 32'(cyc >= REC), 32'h1);
    runCmd(8'h00, 16'h1, 48'h10, 8'h20, 8'h51, 8'h40, cyc);
    runCmd(8'h00, 16'h1, 48'h18, 8'h20, 8'h50, 8'h00, cyc);
    runCmd(8'h00, 16'h1, 48'h11, 8'h35, 8'h50, 8'h00, cyc);
    runCmd(8'h00, 16'h1, 48'h17, 8'h20, 8'h50, 8'h00, cyc);
    runCmd(8'haa, 16'h2, 48'h100, 8'h45, 8'h50, 8'h00, cyc);
    runCmd(8'h00, 16'h1, 48'h101, 8'h20, 8'h51, 8'h40, cyc);
  endtask : testPseudo
  task automatic testAbort();
    wr(IRQ_STATUS_OFS, 32'h3);
    wr(IRQ_MASK_OFS, 32'h3);
    runCmd(8'h12, 16'h1, 48'h200, 8'h45, 8'h51, 8'h04, cyc);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(IRQ_STATUS_OFS, 32'h3);
    repeat (2) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    wr(IRQ_MASK_OFS, 32'h0);
    runCmd(8'h00, 16'h1, 48'h200, 8'h45, 8'h51, 8'h04, cyc);
    check("irq masked", {31'h0, irq}, 32'h0);
    rd(IRQ_STATUS_OFS);
    check("irq status", q, 32'h3);
    runCmd(8'h00, 16'h1, 48'h200, 8'h20, 8'h50, 8'h00, cyc);
  endtask : testAbort
  task automatic testDefectPersist();
    runCmd(8'haa, 16'h1, 48'h300, 8'h45, 8'h50, 8'h00, cyc);
    mediaDefect <= 1'b1;
    runCmd(8'h00, 16'h1, 48'h300, 8'h30, 8'h51, 8'h10, cyc);
    mediaDefect <= 1'b0;
    runCmd(8'haa, 16'h1, 48'h400, 8'h45, 8'h50, 8'h00, cyc);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    runCmd(8'h00, 16'h1, 48'h400, 8'h24, 8'h51, 8'h40, cyc);
    runCmd(8'h55, 16'h0, 48'h1000, 8'h45, 8'h51, 8'h04, cyc);
  endtask : testDefectPersist
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    powerOnRst <= 1'b0;
    testReset();
    testFlagged();
    testPseudo();
    testAbort();
    testDefectPersist();
    results();
  end
  // Watchdog well beyond the roughly 1400 cycles the scenarios need
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule : write_uncorrectable_marker_tb_top
`default_nettype wire
